// >>> src/ccd_descriptor.sv
/*
  Command capability descriptor: three read-only capability fields built
  from configuration inputs, plus a format scope decoder that applies the
  format attributes to each format request.
  Assumes a synchronous register master that never needs wait states and
  configuration inputs that are stable from reset release to the capture edge.
*/
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "ccd_params.svh"

// Summary of operation
// R1 - Bit 5 set exactly when reservations implemented
// R2 - Reservation support needs all four commands
// R3 - Bit 4 only with save and select
// R4 - Bit 3 reports Write Zeroes support
// R5 - Bit 2 reports Dataset Management support
// R6 - Bit 1 reports Write Uncorrectable support
// R7 - Bit 0 reports standalone Compare support
// R8 - Optional command bits 15:6 reserved
// R9 - Fused bit 0 only with compare-write
// R10 - Host sends compare first, write second
// R11 - Fused bits 15:1 reserved
// R12 - Format bit 2 reports cryptographic erase
// R13 - Bit 1 set: erase hits every namespace
// R14 - Bit 1 clear: erase only target namespace
// R15 - Bit 0 set: format covers all namespaces
// R16 - Bit 0 clear: per namespace format allowed
// R17 - Format attribute bits 7:3 reserved
// R18 - Reserved bits zero, fields constant, writes ignored
module ccd_descriptor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire ccd_pkg::ccd_cfg_s cfg,
  input wire logic [11:0] addr,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic cap_ready,
  output logic [15:0] opt_cmd_support,
  output logic [15:0] fused_op_support,
  output logic [7:0] format_attr,
  output ccd_pkg::ccd_fmt_s fmt_out
);

  ////////////////////////////////////////////////////////////////////////
  // State

  ccd_pkg::ccd_state_s s;
  ccd_pkg::ccd_state_s next_s;

  localparam ccd_pkg::ccd_fmt_s FMT_RST = '{
    start: 1'b0,
    nsid: 8'h00,
    erase: `CCD_ERASE_NONE,
    all_ns: 1'b0,
    erase_all: 1'b0,
    reject: 1'b0
  };

  localparam ccd_pkg::ccd_state_s STATE_RST = '{
    st: ccd_pkg::CCD_ST_CAPTURE,
    opt_cmd: `CCD_OPT_CMD_RST,
    fused_ops: `CCD_FUSED_RST,
    fmt_attr: `CCD_FMT_ATTR_RST,
    rd_data: `CCD_RD_DATA_RST,
    rd_valid: 1'b0,
    fmt: FMT_RST
  };

  ////////////////////////////////////////////////////////////////////////
  // Field builders from configuration

  logic resv_all;
  logic [15:0] opt_cmd_val;
  logic [15:0] fused_val;
  logic [7:0] fmt_attr_val;

  always_comb
  begin
    // Partial reservation support is never advertised
    resv_all = cfg.resv_report & cfg.resv_register & cfg.resv_acquire
      & cfg.resv_release; // [R2]
    opt_cmd_val = 16'h0000; // [R8]
    opt_cmd_val[`CCD_OPT_RESV_BIT] = resv_all; // [R1]
    opt_cmd_val[`CCD_OPT_FEAT_SAVE_SEL_BIT] = cfg.feat_save & cfg.feat_select; // [R3]
    opt_cmd_val[`CCD_OPT_WRITE_ZEROES_BIT] = cfg.write_zeroes; // [R4]
    opt_cmd_val[`CCD_OPT_DATASET_MGMT_BIT] = cfg.dataset_mgmt; // [R5]
    opt_cmd_val[`CCD_OPT_WRITE_UNCORR_BIT] = cfg.write_uncorr; // [R6]
    opt_cmd_val[`CCD_OPT_COMPARE_BIT] = cfg.compare; // [R7]
    fused_val = 16'h0000; // [R11]
    fused_val[`CCD_FUSED_CMP_WRITE_BIT] = cfg.fused_cmp_write; // [R9] [R10]
    fmt_attr_val = 8'h00; // [R17]
    fmt_attr_val[`CCD_FMT_CRYPTO_ERASE_BIT] = cfg.crypto_erase; // [R12]
    fmt_attr_val[`CCD_FMT_ERASE_ALL_NS_BIT] = cfg.erase_all_ns;
    fmt_attr_val[`CCD_FMT_FORMAT_ALL_NS_BIT] = cfg.format_all_ns;
  end

  ////////////////////////////////////////////////////////////////////////
  // Format request decode

  logic [7:0] req_nsid;
  logic [1:0] req_erase;
  logic req_all_ns;
  logic req_erase_all;
  logic req_reject;

  always_comb
  begin
    req_nsid = wr_data[`CCD_REQ_NSID_LSB +: 8];
    req_erase = wr_data[`CCD_REQ_ERASE_LSB +: 2];
    req_all_ns = s.fmt_attr[`CCD_FMT_FORMAT_ALL_NS_BIT]; // [R15] [R16]
    // Scope of the erase follows bit 1 only when an erase is asked for
    req_erase_all = (req_erase != `CCD_ERASE_NONE)
      & s.fmt_attr[`CCD_FMT_ERASE_ALL_NS_BIT]; // [R13] [R14]
    req_reject = 1'b0;
    if (req_erase == `CCD_ERASE_CRYPTO && !s.fmt_attr[`CCD_FMT_CRYPTO_ERASE_BIT])
    begin
      req_reject = 1'b1; // [R12]
    end
    else if (req_erase != `CCD_ERASE_NONE && req_erase != `CCD_ERASE_USER
      && req_erase != `CCD_ERASE_CRYPTO)
    begin
      req_reject = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux

  logic [15:0] rd_mux;

  always_comb
  begin
    rd_mux = 16'h0000;
    case (addr)
      `CCD_OFS_OPT_CMD:
      begin
        rd_mux = s.opt_cmd;
      end
      `CCD_OFS_FUSED:
      begin
        rd_mux = s.fused_ops;
      end
      `CCD_OFS_FMT_ATTR:
      begin
        rd_mux = {8'h00, s.fmt_attr};
      end
      `CCD_OFS_FMT_STAT:
      begin
        rd_mux[`CCD_STAT_ALL_NS_BIT] = s.fmt.all_ns;
        rd_mux[`CCD_STAT_ERASE_ALL_BIT] = s.fmt.erase_all;
        rd_mux[`CCD_STAT_REJECT_BIT] = s.fmt.reject;
        rd_mux[`CCD_STAT_NSID_LSB +: 8] = s.fmt.nsid;
      end
      default:
      begin
        // Unmapped and write-only offsets read as zero
        rd_mux = 16'h0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_s = s;
    next_s.rd_valid = 1'b0;
    next_s.rd_data = `CCD_RD_DATA_RST;
    next_s.fmt.start = 1'b0;

    case (s.st)
      ccd_pkg::CCD_ST_CAPTURE:
      begin
        // Configuration is sampled once after reset, then frozen
        next_s.opt_cmd = opt_cmd_val;
        next_s.fused_ops = fused_val;
        next_s.fmt_attr = fmt_attr_val;
        next_s.st = ccd_pkg::CCD_ST_RUN;
      end
      ccd_pkg::CCD_ST_RUN:
      begin
        // Capability fields hold; bus writes never reach them
        next_s.opt_cmd = s.opt_cmd; // [R18]
        if (wr_en && addr == `CCD_OFS_FMT_REQ)
        begin
          next_s.fmt.start = ~req_reject;
          next_s.fmt.reject = req_reject;
          next_s.fmt.erase = req_erase;
          next_s.fmt.all_ns = req_all_ns;
          next_s.fmt.erase_all = req_erase_all;
          // A whole-device format names every namespace
          next_s.fmt.nsid = req_all_ns ? `CCD_NSID_ALL : req_nsid; // [R15] [R16]
        end
      end
      default:
      begin
        next_s.st = ccd_pkg::CCD_ST_CAPTURE;
      end
    endcase

    if (rd_en)
    begin
      next_s.rd_valid = 1'b1;
      next_s.rd_data = rd_mux; // [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s <= STATE_RST;
    end
    else if (ce)
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  always_comb
  begin
    rd_data = s.rd_data;
    rd_valid = s.rd_valid;
    cap_ready = (s.st == ccd_pkg::CCD_ST_RUN);
    opt_cmd_support = s.opt_cmd;
    fused_op_support = s.fused_ops;
    format_attr = s.fmt_attr;
    fmt_out = s.fmt;
  end

endmodule

// >>> src/ccd_params.svh
/*
  Offsets, field positions, reset values and encodings of the command
  capability descriptor. Included by the package users; no logic here.
*/
`ifndef CCD_PARAMS_SVH
`define CCD_PARAMS_SVH

`define CCD_ADDR_W 12
`define CCD_DATA_W 16

`define CCD_OFS_OPT_CMD 12'h208
`define CCD_OFS_FUSED 12'h20A
`define CCD_OFS_FMT_ATTR 12'h20C
`define CCD_OFS_FMT_REQ 12'h210
`define CCD_OFS_FMT_STAT 12'h212

`define CCD_OPT_RESV_BIT 5
`define CCD_OPT_FEAT_SAVE_SEL_BIT 4
`define CCD_OPT_WRITE_ZEROES_BIT 3
`define CCD_OPT_DATASET_MGMT_BIT 2
`define CCD_OPT_WRITE_UNCORR_BIT 1
`define CCD_OPT_COMPARE_BIT 0
`define CCD_FUSED_CMP_WRITE_BIT 0
`define CCD_FMT_CRYPTO_ERASE_BIT 2
`define CCD_FMT_ERASE_ALL_NS_BIT 1
`define CCD_FMT_FORMAT_ALL_NS_BIT 0

`define CCD_REQ_NSID_LSB 0
`define CCD_REQ_ERASE_LSB 8
`define CCD_STAT_ALL_NS_BIT 0
`define CCD_STAT_ERASE_ALL_BIT 1
`define CCD_STAT_REJECT_BIT 2
`define CCD_STAT_NSID_LSB 8

`define CCD_OPT_CMD_RST 16'h0000
`define CCD_FUSED_RST 16'h0000
`define CCD_FMT_ATTR_RST 8'h00
`define CCD_RD_DATA_RST 16'h0000
`define CCD_NSID_ALL 8'hFF

`define CCD_ERASE_NONE 2'h0
`define CCD_ERASE_USER 2'h1
`define CCD_ERASE_CRYPTO 2'h2

`endif

// >>> src/ccd_pkg.sv
/*
  Types of the command capability descriptor: state encoding, the
  configuration bundle and the whole module state. Assumes nothing.
*/
package ccd_pkg;

  typedef enum logic [1:0] {
    CCD_ST_CAPTURE = 2'b01,
    CCD_ST_RUN = 2'b10
  } ccd_state_e;

  typedef struct packed {
    logic resv_report;
    logic resv_register;
    logic resv_acquire;
    logic resv_release;
    logic feat_save;
    logic feat_select;
    logic write_zeroes;
    logic dataset_mgmt;
    logic write_uncorr;
    logic compare;
    logic fused_cmp_write;
    logic crypto_erase;
    logic erase_all_ns;
    logic format_all_ns;
  } ccd_cfg_s;

  typedef struct packed {
    logic start;
    logic [7:0] nsid;
    logic [1:0] erase;
    logic all_ns;
    logic erase_all;
    logic reject;
  } ccd_fmt_s;

  typedef struct packed {
    ccd_state_e st;
    logic [15:0] opt_cmd;
    logic [15:0] fused_ops;
    logic [7:0] fmt_attr;
    logic [15:0] rd_data;
    logic rd_valid;
    ccd_fmt_s fmt;
  } ccd_state_s;

endpackage

// >>> dv/ccd_host_model.sv
/*
  Host side of the register port: turns one-cycle requests into strobes.
  Assumes the bench pulses go for one cycle per access.
*/
`timescale 1ns/1ns
module ccd_host_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic wr,
  input wire logic [11:0] a,
  input wire logic [15:0] d,
  output logic [11:0] addr,
  output logic wr_en,
  output logic [15:0] wr_data,
  output logic rd_en
);
  // Single accesses only, never fused pairs, so compare-first order holds
  always_ff @(posedge clk_sys)
  begin
    wr_en <= go & wr;
    rd_en <= go & ~wr;
    // Idle bus toggles so a stale address never passes for a request
    addr <= go ? a : ~addr;
    wr_data <= go ? d : ~wr_data;
  end
endmodule

// >>> dv/ccd_monitor.sv
/*
  Checker of the descriptor ports.
  Assumes cfg holds until the capture edge.
*/
`timescale 1ns/1ns
module ccd_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire ccd_pkg::ccd_cfg_s cfg,
  input wire logic [11:0] addr,
  input wire logic rd_en,
  input wire logic [15:0] rd_data,
  input wire logic cap_ready,
  input wire logic [15:0] opt_cmd_support,
  input wire logic [15:0] fused_op_support,
  input wire logic [7:0] format_attr,
  input wire ccd_pkg::ccd_fmt_s fmt_out
);
  // Copy of cfg at the capture edge; later changes must not show
  ccd_pkg::ccd_cfg_s c;
  always_ff @(posedge clk_sys)
  begin
    if (!cap_ready)
      c <= cfg;
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  a_resv_bit: assert property (cap_ready |->
    opt_cmd_support[5] == &{c.resv_report, c.resv_register, c.resv_acquire, c.resv_release}) else $error("resv bit");
  a_save_sel: assert property (cap_ready |-> opt_cmd_support[4] == (c.feat_save & c.feat_select))
    else $error("save bit");
  a_cmd_bits: assert property (cap_ready |->
    opt_cmd_support[3:0] == {c.write_zeroes, c.dataset_mgmt, c.write_uncorr, c.compare}) else $error("cmd bits");
  a_rsvd_zero: assert property (opt_cmd_support[15:6] == 0 && fused_op_support[15:1] == 0
    && format_attr[7:3] == 0) else $error("reserved bits");
  a_fused_bit: assert property (cap_ready |-> fused_op_support[0] == c.fused_cmp_write) else $error("fused");
  a_fmt_bits: assert property (cap_ready |->
    format_attr[2:0] == {c.crypto_erase, c.erase_all_ns, c.format_all_ns}) else $error("format bits");
  a_held_const: assert property (cap_ready && $past(cap_ready) |->
    $stable({opt_cmd_support, fused_op_support, format_attr})) else $error("field changed");
  a_read_attr: assert property (cap_ready && ce && rd_en && addr == 12'h20C |=>
    rd_data == {8'h00, format_attr}) else $error("attr read");
  a_ns_scope: assert property (fmt_out.start |-> fmt_out.all_ns == format_attr[0]
    && (!fmt_out.all_ns || fmt_out.nsid == 8'hFF)) else $error("ns scope");
  a_erase_scope: assert property (fmt_out.start |->
    fmt_out.erase_all == (format_attr[1] && fmt_out.erase != 2'h0)) else $error("erase scope");
endmodule
bind ccd_descriptor ccd_monitor i_ccd_monitor (.clk_sys, .rst, .ce, .cfg, .addr, .rd_en, .rd_data, .cap_ready,
  .opt_cmd_support, .fused_op_support, .format_attr, .fmt_out);

// >>> dv/testbench.sv
/*
  Self-checking bench of the capability descriptor.
  Needs the host model and the bound checker.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [11:0] a = 12'h000;
  logic [15:0] d = 16'h0000;
  logic [11:0] addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic wr_en;
  logic rd_en;
  logic rd_valid;
  ccd_pkg::ccd_cfg_s cfg = '0;
  int fail_count = 0;
  int compares = 0;
  always #2 clk_sys = ~clk_sys;
  ccd_host_model i_ccd_host_model (.clk_sys, .go, .wr, .a, .d, .addr, .wr_en, .wr_data, .rd_en);
  ccd_descriptor i_ccd_descriptor (.clk_sys, .rst, .ce(1'b1), .cfg, .addr, .wr_en, .wr_data, .rd_en, .rd_data,
    .rd_valid, .cap_ready(), .opt_cmd_support(), .fused_op_support(), .format_attr(), .fmt_out());
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_opt(input ccd_pkg::ccd_cfg_s c);
    return {10'h000, c.resv_report & c.resv_register & c.resv_acquire & c.resv_release,
      c.feat_save & c.feat_select, c.write_zeroes, c.dataset_mgmt, c.write_uncorr, c.compare};
  endfunction
  function automatic logic [15:0] exp_stat(input ccd_pkg::ccd_cfg_s c, input logic [7:0] n, input logic [1:0] e);
    return {c.format_all_ns ? 8'hFF : n, 6'h00, c.erase_all_ns && e != 2'h0, c.format_all_ns};
  endfunction
  // Read data is sampled just after the edge that follows the strobe
  task automatic acc(input logic w, input logic [11:0] ad, input logic [15:0] dt);
    @(posedge clk_sys);
    go <= 1'b1;
    wr <= w;
    a <= ad;
    d <= dt;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic conclude;
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    ccd_pkg::ccd_cfg_s c;
    logic [7:0] n;
    logic [1:0] e;
    void'($urandom(32'h67177041));
    for (int i = 0; i < 24; i++)
    begin
      // Corners: all set, all clear, one reservation command missing
      c = (i == 0) ? 14'h3FFF : (i == 1) ? 14'h0000 : (i == 2) ? 14'h3BFF : 14'($urandom);
      n = 8'($urandom);
      e = (i < 4) ? 2'(i) : 2'($urandom);
      @(posedge clk_sys);
      cfg <= c;
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      acc(1'b0, 12'h208, 16'h0000);
      `CHK(rd_data, exp_opt(c))
      `CHK(rd_valid, 1'b1)
      acc(1'b1, 12'h208, 16'hFFFF);
      `CHK(rd_valid, 1'b0)
      cfg <= ~c;
      acc(1'b0, 12'h208, 16'h0000);
      `CHK(rd_data, exp_opt(c))
      acc(1'b0, 12'h20A, 16'h0000);
      `CHK(rd_data, {15'h0000, c.fused_cmp_write})
      acc(1'b0, 12'h20C, 16'h0000);
      `CHK(rd_data, {13'h0000, c.crypto_erase, c.erase_all_ns, c.format_all_ns})
      acc(1'b0, 12'h40E, 16'h0000);
      `CHK(rd_data, 16'h0000)
      acc(1'b1, 12'h210, {6'h00, e, n});
      acc(1'b0, 12'h212, 16'h0000);
      if (e == 2'h3 || (e == 2'h2 && !c.crypto_erase))
        `CHK(rd_data[2], 1'b1)
      else
        `CHK(rd_data, exp_stat(c, n, e))
    end
    conclude;
  end
  initial
  begin
    #20000;
    fail_count++;
    conclude;
  end
endmodule
